// ### sdmc_cfg.svh
// Register offsets, field positions, command and response codes and timing counts of the sensor data monitor.
// Assumes a 25 MHz system clock; included by bare name.
`ifndef SDMC_CFG_SVH
`define SDMC_CFG_SVH
`define SDMC_OFF_STATUS 8'h10
`define SDMC_OFF_CFG11 8'h11
`define SDMC_OFF_TRIM 8'h13
`define SDMC_OFF_LOGCFG 8'h14
`define SDMC_OFF_TIMING 8'h15
`define SDMC_OFF_XLIM 8'h16
`define SDMC_OFF_YLIM 8'h17
`define SDMC_OFF_XCOEF 8'h18
`define SDMC_OFF_YCOEF 8'h19
`define SDMC_OFF_COMP 8'h1a
`define SDMC_OFF_CAL 8'h1b
`define SDMC_CUSTOM_CMD 8'ha0
`define SDMC_LOG_FIRST 8'h1c
`define SDMC_LOG_LAST 8'hff
`define SDMC_WAKE_CMD 8'h20
`define SDMC_ST_STARTED 7
`define SDMC_ST_ACTIVE 6
`define SDMC_ST_OVERFLOW 5
`define SDMC_ST_WDOG 4
`define SDMC_ST_BATT 3
`define SDMC_ST_ALARM 2
`define SDMC_ST_OUTBAND 1
`define SDMC_ST_IRQ 0
`define SDMC_RSP_NONE 4'h0
`define SDMC_RSP_BEGUN 4'h4
`define SDMC_RSP_HALTED 4'h8
`define SDMC_RSP_WORKING 4'he
`define SDMC_MINUTE_S 60
`define SDMC_CLK_HZ 25000000
`define SDMC_MINUTE_CYC (`SDMC_MINUTE_S * `SDMC_CLK_HZ)
`endif

// ### sdmc_pkg.sv
// Types shared by the sensor data monitor control block.
// Assumes nothing beyond the configuration header.
package sdmc_pkg;
   typedef enum logic [1:0] {
      SDMC_IDLE = 2'b00,
      SDMC_DELAY = 2'b01,
      SDMC_WAIT = 2'b10,
      SDMC_MEAS = 2'b11
   } sdmc_state_e;
   typedef struct packed {
      logic [11:0] x_avg;
      logic [11:0] y_avg;
      logic [11:0] temp_avg;
      logic valid;
      logic battery_low;
   } sdmc_sample_s;
   typedef struct packed {
      logic [7:0] x_norm;
      logic [7:0] y_norm;
      logic irq;
      logic store;
   } sdmc_result_s;
endpackage

// ### sdmc_monitor.sv
// Control logic of the sensor data monitor: configuration words, command decode and sequencing.
// Assumes the RF front end delivers word writes and custom commands as one-cycle strobes on CLK,
// and that the analog front end delivers averaged samples on CLK. Pin inputs are synchronised.
// Notes on behaviour
// - Interrupt area size zero means the interrupt-mode bit is ignored.
// - Alarm output low while logged count exceeds the alarm threshold.
// - Alarm released on monitor off, low battery or full memory.
// - Temperature average over two to the exponent samples, also used for outband.
// - Log area end valid 1Ch to FFh; smaller writes become 1Ch.
// - Without digital sensor, power down after the internal log cycles.
// - Timer loads the measure period; zero means measure continuously.
// - First measurement waits start delay times one minute.
// - Twelve-bit upper and lower interrupt limits per external sensor.
// - Normalised value is bits 11:4 of average times gain plus offset.
// - Per sensor positive and negative compensation enables and 6-bit values.
// - Monitor commands arrive in custom command A0h, low four bits.
// - Response set to all ones, command executed, then outcome written.
// - 0000 idle, 0100 start with cal and outband bits, 1000 stop.
// - Responses none, begun, halted, working, echoing cal and outband bits.
// - Calibration start calibrates, stores data, stops and powers down.
// - Start clears count; last log write stops monitor and increments count.
// - Low battery before measuring stops monitor and sets battery error unless disabled.
// - Power down on stop unless digital sensor present without power-down request.
// - RF write to words 11h to 1Bh stops monitor and clears status and count.
// - Bits 3:2 select start, stop or idle; value 20h wakes the digital sensor.
// - Response byte holds 000, wakeup state in bit 4, response code in 3:0.
// - Status bits started, active, overflow, watchdog, battery, alarm, outband, interrupt.
// - Reset clears status, logged count and releases the alarm.
// - In interrupt mode store external data only on interrupt, else always.
`timescale 1ns/1ps
`default_nettype none
`include "sdmc_cfg.svh"
module sdmc_monitor #(
   parameter int unsigned MINUTE_CYCLES = `SDMC_MINUTE_CYC
) (
   input wire logic CLK,
   input wire logic RSTN,
   input wire logic CE,
   input wire logic WR_STB,
   input wire logic [7:0] WR_ADDR,
   input wire logic [31:0] WR_DATA,
   input wire logic [7:0] RD_ADDR,
   output logic [31:0] RD_DATA,
   input wire logic CMD_STB,
   input wire logic [7:0] CMD_CODE,
   input wire logic [7:0] CMD_BYTE,
   output logic [7:0] RSP_BYTE,
   input wire sdmc_pkg::sdmc_sample_s SAMPLE,
   output sdmc_pkg::sdmc_result_s RESULT,
   output logic MEAS_REQ,
   output logic CAL_REQ,
   output logic [7:0] LOG_ADDR,
   input wire logic LOG_WRITTEN,
   input wire logic BATT_CHECK_DISABLE,
   input wire logic EXT_POWERDOWN_REQUEST,
   output logic POWER_DOWN,
   output logic ALARM_O,
   output logic ALARM_OE,
   output logic [5:0] X_POS_COMP,
   output logic [5:0] X_NEG_COMP,
   output logic [5:0] Y_POS_COMP,
   output logic [5:0] Y_NEG_COMP,
   output logic [3:0] COMP_EN,
   output logic [3:0] TEMP_AVG_EXPONENT,
   output logic [2:0] EXT_AVG_EXPONENT
);
   import sdmc_pkg::*;

   logic [31:0] cfg11_r, trim_r, logcfg_r, timing_r, xlim_r, ylim_r, xcoef_r, ycoef_r;
   logic [31:0] comp_r, cal_r;
   logic [7:0] status_r, logged_block_count_r, rsp_code_r;
   logic wake_r, pdn_r;
   logic [1:0] sync_bcd_r, sync_epd_r;
   sdmc_state_e state_r;
   logic [15:0] min_left_r;
   logic [31:0] tick_r;
   logic [7:0] log_ptr_r;
   logic [2:0] cmd_phase_r;
   logic [7:0] cmd_hold_r;
   logic cal_mode_r;

   wire logic bcd = sync_bcd_r[1];
   wire logic epd = sync_epd_r[1];
   wire logic [7:0] irq_area_size = logcfg_r[31:24];
   wire logic [7:0] alarm_threshold = logcfg_r[23:16];
   wire logic ext_digital_sensor_present = logcfg_r[15];
   wire logic [7:0] log_area_end = logcfg_r[7:0];
   wire logic [7:0] measure_period = timing_r[7:0];
   wire logic [15:0] start_delay = timing_r[31:16];
   wire logic irq_mode = cfg11_r[3] && (irq_area_size != 8'h00);
   wire logic minute_tick = (tick_r == MINUTE_CYCLES - 1);
   wire logic cfg_write = WR_STB && WR_ADDR >= `SDMC_OFF_CFG11 && WR_ADDR <= `SDMC_OFF_CAL;
   wire logic mon_cmd = CMD_STB && CMD_CODE == `SDMC_CUSTOM_CMD;
   wire logic [1:0] cmd_sel = CMD_BYTE[3:2];
   wire logic is_start = mon_cmd && cmd_sel == 2'b01;
   wire logic is_stop = mon_cmd && cmd_sel == 2'b10;
   wire logic running = state_r != SDMC_IDLE;
   wire logic batt_fail = SAMPLE.valid && SAMPLE.battery_low && !bcd;
   wire logic last_write = LOG_WRITTEN && log_ptr_r == log_area_end;
   wire logic halt = is_stop || cfg_write || batt_fail || last_write || (cal_mode_r && LOG_WRITTEN);

   // Product plus offset in signed arithmetic; the sample itself is unsigned.
   function automatic logic [7:0] norm(input logic [11:0] avg, input logic [11:0] gain,
                                       input logic [11:0] offs);
      logic signed [25:0] acc;
      acc = $signed({14'h0, avg}) * $signed(gain) + $signed(offs);
      return acc[11:4];
   endfunction

   function automatic logic outside(input logic [11:0] v, input logic [31:0] lim);
      return (v > lim[27:16]) || (v < lim[11:0]);
   endfunction

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         sync_bcd_r <= 2'b00;
         sync_epd_r <= 2'b00;
      end else if (CE) begin
         sync_bcd_r <= {sync_bcd_r[0], BATT_CHECK_DISABLE};
         sync_epd_r <= {sync_epd_r[0], EXT_POWERDOWN_REQUEST};
      end
   end

   // Configuration words are storage written by the RF side; the limit words keep only their 12-bit fields.
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         cfg11_r <= 32'h0;
         trim_r <= 32'h0;
         logcfg_r <= {24'h0, `SDMC_LOG_LAST};
         timing_r <= 32'h0;
         xlim_r <= 32'h0;
         ylim_r <= 32'h0;
         xcoef_r <= 32'h0;
         ycoef_r <= 32'h0;
         comp_r <= 32'h0;
         cal_r <= 32'h0;
      end else if (CE && WR_STB) begin
         if (WR_ADDR == `SDMC_OFF_CFG11) begin
            cfg11_r <= WR_DATA;
         end else if (WR_ADDR == `SDMC_OFF_TRIM) begin
            trim_r <= WR_DATA;
         end else if (WR_ADDR == `SDMC_OFF_LOGCFG) begin
            logcfg_r[31:8] <= WR_DATA[31:8];
            // Below the first log word is out of range; the smallest legal end is kept.
            logcfg_r[7:0] <= (WR_DATA[7:0] < `SDMC_LOG_FIRST) ? `SDMC_LOG_FIRST : WR_DATA[7:0];
         end else if (WR_ADDR == `SDMC_OFF_TIMING) begin
            timing_r <= WR_DATA;
         end else if (WR_ADDR == `SDMC_OFF_XLIM) begin
            xlim_r <= {4'h0, WR_DATA[27:16], 4'h0, WR_DATA[11:0]};
         end else if (WR_ADDR == `SDMC_OFF_YLIM) begin
            ylim_r <= {4'h0, WR_DATA[27:16], 4'h0, WR_DATA[11:0]};
         end else if (WR_ADDR == `SDMC_OFF_XCOEF) begin
            xcoef_r <= WR_DATA;
         end else if (WR_ADDR == `SDMC_OFF_YCOEF) begin
            ycoef_r <= WR_DATA;
         end else if (WR_ADDR == `SDMC_OFF_COMP) begin
            comp_r <= WR_DATA;
         end else if (WR_ADDR == `SDMC_OFF_CAL) begin
            cal_r <= WR_DATA;
         end
      end
   end

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         RD_DATA <= 32'h0;
      end else if (CE) begin
         if (RD_ADDR == `SDMC_OFF_STATUS) begin
            RD_DATA <= {16'h0, status_r, logged_block_count_r};
         end else if (RD_ADDR == `SDMC_OFF_CFG11) begin
            RD_DATA <= cfg11_r;
         end else if (RD_ADDR == `SDMC_OFF_TRIM) begin
            RD_DATA <= trim_r;
         end else if (RD_ADDR == `SDMC_OFF_LOGCFG) begin
            RD_DATA <= logcfg_r;
         end else if (RD_ADDR == `SDMC_OFF_TIMING) begin
            RD_DATA <= timing_r;
         end else if (RD_ADDR == `SDMC_OFF_XLIM) begin
            RD_DATA <= xlim_r;
         end else if (RD_ADDR == `SDMC_OFF_YLIM) begin
            RD_DATA <= ylim_r;
         end else if (RD_ADDR == `SDMC_OFF_XCOEF) begin
            RD_DATA <= xcoef_r;
         end else if (RD_ADDR == `SDMC_OFF_YCOEF) begin
            RD_DATA <= ycoef_r;
         end else if (RD_ADDR == `SDMC_OFF_COMP) begin
            RD_DATA <= comp_r;
         end else if (RD_ADDR == `SDMC_OFF_CAL) begin
            RD_DATA <= cal_r;
         end else begin
            RD_DATA <= 32'h0;
         end
      end
   end

   // Command sequencing: all ones first, then the outcome two cycles later.
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         cmd_phase_r <= 3'h0;
         cmd_hold_r <= 8'h0;
         rsp_code_r <= 8'h0;
         wake_r <= 1'b0;
      end else if (CE) begin
         cmd_phase_r <= {cmd_phase_r[1:0], mon_cmd};
         if (mon_cmd) begin
            cmd_hold_r <= CMD_BYTE;
            rsp_code_r <= 8'hff;
            if (CMD_BYTE == `SDMC_WAKE_CMD) begin
               wake_r <= 1'b1;
            end
         end else if (cmd_phase_r[1]) begin
            if (cmd_hold_r[3:2] == 2'b01) begin
               rsp_code_r <= {4'h0, `SDMC_RSP_BEGUN | {2'b00, cmd_hold_r[1:0]}};
            end else if (cmd_hold_r[3:2] == 2'b10) begin
               rsp_code_r <= {4'h0, `SDMC_RSP_HALTED | {2'b00, status_r[`SDMC_ST_OUTBAND], cal_mode_r}};
            end else if (running) begin
               rsp_code_r <= {4'h0, `SDMC_RSP_WORKING | {3'b000, cal_mode_r}};
            end else begin
               rsp_code_r <= {4'h0, `SDMC_RSP_NONE};
            end
         end
      end
   end

   assign RSP_BYTE = (rsp_code_r == 8'hff) ? 8'hff : {3'b000, wake_r, rsp_code_r[3:0]};

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         state_r <= SDMC_IDLE;
         min_left_r <= 16'h0;
         tick_r <= 32'h0;
         cal_mode_r <= 1'b0;
      end else if (CE) begin
         tick_r <= (minute_tick || !running) ? 32'h0 : tick_r + 32'h1;
         if (halt) begin
            state_r <= SDMC_IDLE;
            cal_mode_r <= 1'b0;
         end else if (is_start) begin
            cal_mode_r <= CMD_BYTE[0];
            state_r <= (start_delay == 16'h0) ? SDMC_MEAS : SDMC_DELAY;
            min_left_r <= start_delay;
         end else begin
            case (state_r)
               SDMC_DELAY: begin
                  if (minute_tick) begin
                     min_left_r <= min_left_r - 16'h1;
                     if (min_left_r == 16'h1) begin
                        state_r <= SDMC_MEAS;
                     end
                  end
               end
               SDMC_WAIT: begin
                  if (measure_period == 8'h00) begin
                     state_r <= SDMC_MEAS;
                  end else if (minute_tick) begin
                     min_left_r <= min_left_r - 16'h1;
                     if (min_left_r == 16'h1) begin
                        state_r <= SDMC_MEAS;
                     end
                  end
               end
               SDMC_MEAS: begin
                  if (SAMPLE.valid) begin
                     state_r <= SDMC_WAIT;
                     min_left_r <= {8'h0, measure_period};
                  end
               end
               default: begin
                  state_r <= SDMC_IDLE;
               end
            endcase
         end
      end
   end

   assign MEAS_REQ = (state_r == SDMC_MEAS) && !cal_mode_r;
   assign CAL_REQ = (state_r == SDMC_MEAS) && cal_mode_r;

   // Status and count; the final write both clears the active bit and still advances the count.
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         status_r <= 8'h0;
         logged_block_count_r <= 8'h0;
         log_ptr_r <= `SDMC_LOG_FIRST;
      end else if (CE) begin
         if (cfg_write) begin
            status_r <= 8'h0;
            logged_block_count_r <= 8'h0;
            log_ptr_r <= `SDMC_LOG_FIRST;
         end else if (is_start) begin
            status_r <= 8'h0;
            status_r[`SDMC_ST_STARTED] <= 1'b1;
            status_r[`SDMC_ST_ACTIVE] <= 1'b1;
            status_r[`SDMC_ST_OUTBAND] <= CMD_BYTE[1];
            logged_block_count_r <= 8'h0;
            log_ptr_r <= `SDMC_LOG_FIRST + irq_area_size;
         end else begin
            if (halt) begin
               status_r[`SDMC_ST_ACTIVE] <= 1'b0;
            end
            if (batt_fail && running) begin
               status_r[`SDMC_ST_BATT] <= 1'b1;
            end
            if (last_write) begin
               status_r[`SDMC_ST_OVERFLOW] <= 1'b1;
            end
            // Judged on the sample now arriving, not on the result registered from the last one.
            if (SAMPLE.valid && irq_mode &&
                (outside(SAMPLE.x_avg, xlim_r) || outside(SAMPLE.y_avg, ylim_r))) begin
               status_r[`SDMC_ST_IRQ] <= 1'b1;
            end
            status_r[`SDMC_ST_ALARM] <= ALARM_OE;
            if (LOG_WRITTEN) begin
               logged_block_count_r <= logged_block_count_r + 8'h1;
               log_ptr_r <= log_ptr_r + 8'h1;
            end
         end
      end
   end

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         pdn_r <= 1'b0;
      end else if (CE) begin
         if (is_start || (mon_cmd && CMD_BYTE == `SDMC_WAKE_CMD)) begin
            pdn_r <= 1'b0;
         end else if (halt && running) begin
            // A digital sensor keeps the part awake unless it is asking to sleep when the monitor stops.
            pdn_r <= !ext_digital_sensor_present || epd;
         end
      end
   end

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         RESULT <= '0;
      end else if (CE && SAMPLE.valid) begin
         RESULT.x_norm <= norm(SAMPLE.x_avg, xcoef_r[27:16], xcoef_r[11:0]);
         RESULT.y_norm <= norm(SAMPLE.y_avg, ycoef_r[27:16], ycoef_r[11:0]);
         RESULT.irq <= irq_mode && (outside(SAMPLE.x_avg, xlim_r) || outside(SAMPLE.y_avg, ylim_r));
         RESULT.store <= !irq_mode || outside(SAMPLE.x_avg, xlim_r) ||
                         outside(SAMPLE.y_avg, ylim_r);
      end
   end

   assign POWER_DOWN = pdn_r;
   assign LOG_ADDR = log_ptr_r;
   assign ALARM_O = 1'b0;
   // Once the monitor stops the pin floats again, so a display must latch the event itself.
   assign ALARM_OE = status_r[`SDMC_ST_ACTIVE] && !status_r[`SDMC_ST_BATT] &&
                     !status_r[`SDMC_ST_OVERFLOW] &&
                     (logged_block_count_r > alarm_threshold);
   assign X_POS_COMP = comp_r[13:8];
   assign X_NEG_COMP = comp_r[5:0];
   assign Y_POS_COMP = comp_r[29:24];
   assign Y_NEG_COMP = comp_r[21:16];
   assign COMP_EN = {comp_r[30], comp_r[22], comp_r[14], comp_r[6]};
   assign TEMP_AVG_EXPONENT = logcfg_r[11:8];
   assign EXT_AVG_EXPONENT = cfg11_r[6:4];
endmodule
`default_nettype wire

// ### sdmc_reader.sv
// Reader model: issues word writes, word reads and custom commands to the monitor.
// Assumes CLK is the monitor clock and that the bench keeps the clock enable high.
`timescale 1ns/1ps
`default_nettype none
module sdmc_reader (
   input wire logic clk,
   output logic wr_stb,
   output logic [7:0] wr_addr,
   output logic [31:0] wr_data,
   output logic [7:0] rd_addr,
   input wire logic [31:0] rd_data,
   output logic cmd_stb,
   output logic [7:0] cmd_code,
   output logic [7:0] cmd_byte,
   input wire logic [7:0] rsp_byte
);
   initial begin
      wr_stb = 1'b0;
      wr_addr = 8'h00;
      wr_data = 32'h0;
      rd_addr = 8'h00;
      cmd_stb = 1'b0;
      cmd_code = 8'h00;
      cmd_byte = 8'h00;
   end
   // Released lines are inverted so that a stale value is never mistaken for a held one.
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      #1 wr_stb = 1'b1;
      wr_addr = a;
      wr_data = v;
      @(posedge clk);
      #1 wr_stb = 1'b0;
      wr_addr = ~a;
      wr_data = ~v;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk);
      #1 rd_addr = a;
      repeat (2) @(posedge clk);
      #1 v = rd_data;
   endtask
   // The outcome is taken only after the busy phase, so command strobes stay at least five cycles apart.
   task automatic cmd(input logic [7:0] c, input logic [7:0] b, output logic [7:0] r);
      @(posedge clk);
      #1 cmd_stb = 1'b1;
      cmd_code = c;
      cmd_byte = b;
      @(posedge clk);
      #1 cmd_stb = 1'b0;
      cmd_code = ~c;
      cmd_byte = ~b;
      repeat (3) @(posedge clk);
      #1 r = rsp_byte;
   endtask
endmodule
`default_nettype wire

// ### sdmc_checker_assertions.sv
// Concurrent checks on the monitor's ports, bound into every monitor instance.
// Assumes one clock domain on CLK with RSTN as its asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
module sdmc_checker #(
   parameter int unsigned MINUTE_CYCLES = 4
) (
   input wire logic CLK,
   input wire logic RSTN,
   input wire logic CE,
   input wire logic WR_STB,
   input wire logic [7:0] WR_ADDR,
   input wire logic [31:0] WR_DATA,
   input wire logic CMD_STB,
   input wire logic [7:0] CMD_CODE,
   input wire logic [7:0] CMD_BYTE,
   input wire logic [7:0] RSP_BYTE,
   input wire logic MEAS_REQ,
   input wire logic CAL_REQ,
   input wire logic ALARM_O,
   input wire logic ALARM_OE,
   input wire logic [5:0] X_POS_COMP,
   input wire logic [5:0] X_NEG_COMP,
   input wire logic [5:0] Y_POS_COMP,
   input wire logic [5:0] Y_NEG_COMP,
   input wire logic [3:0] COMP_EN,
   input wire logic [3:0] TEMP_AVG_EXPONENT
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RSTN);
   logic cmd_ok;
   assign cmd_ok = CE && CMD_STB && CMD_CODE == 8'ha0 && CMD_BYTE[7:4] == 4'h0;
   sequence s_busy;
      RSP_BYTE == 8'hff [*2];
   endsequence
   sequence s_start;
      cmd_ok && CMD_BYTE[3:2] == 2'b01;
   endsequence
   sequence s_stop;
      cmd_ok && CMD_BYTE[3:2] == 2'b10;
   endsequence
   AST_RSP_BUSY: assert property (cmd_ok |=> s_busy)
      else $error("response not all ones after a command");
   AST_RSP_TOP: assert property (RSP_BYTE != 8'hff |-> RSP_BYTE[7:5] == 3'b000)
      else $error("response top bits not zero");
   AST_START_RSP: assert property (s_start |=> s_busy ##1
      RSP_BYTE[3:0] == {2'b01, $past(CMD_BYTE[1:0], 3)})
      else $error("wrong outcome after start");
   AST_STOP_RSP: assert property (s_stop |=> s_busy ##1
      (RSP_BYTE[3:2] == 2'b10 && !ALARM_OE && !MEAS_REQ && !CAL_REQ))
      else $error("wrong outcome after stop");
   AST_ALARM_LOW: assert property (ALARM_OE |-> !ALARM_O)
      else $error("alarm pin not driven low");
   AST_COMP: assert property (CE && WR_STB && WR_ADDR == 8'h1a |=>
      X_POS_COMP == $past(WR_DATA[13:8]) && X_NEG_COMP == $past(WR_DATA[5:0]) &&
      Y_POS_COMP == $past(WR_DATA[29:24]) && Y_NEG_COMP == $past(WR_DATA[21:16]) &&
      COMP_EN == {$past(WR_DATA[30]), $past(WR_DATA[22]), $past(WR_DATA[14]), $past(WR_DATA[6])})
      else $error("compensation outputs do not follow the word");
   AST_TEMP_EXP: assert property (CE && WR_STB && WR_ADDR == 8'h14 |=>
      TEMP_AVG_EXPONENT == $past(WR_DATA[11:8]))
      else $error("averaging exponent does not follow the word");
   AST_WR_STOP: assert property (CE && WR_STB && WR_ADDR inside {[8'h11:8'h1b]} |=>
      !MEAS_REQ && !CAL_REQ)
      else $error("configuration write did not stop the monitor");
   AST_CMD_IGNORED: assert property (CE && CMD_STB && CMD_CODE != 8'ha0 &&
      RSP_BYTE != 8'hff |=> $stable(RSP_BYTE) [*3])
      else $error("foreign command changed the response");
endmodule
bind sdmc_monitor sdmc_checker #(.MINUTE_CYCLES(MINUTE_CYCLES)) i_chk (.CLK(CLK), .RSTN(RSTN),
   .CE(CE), .WR_STB(WR_STB), .WR_ADDR(WR_ADDR), .WR_DATA(WR_DATA), .CMD_STB(CMD_STB),
   .CMD_CODE(CMD_CODE), .CMD_BYTE(CMD_BYTE), .RSP_BYTE(RSP_BYTE), .MEAS_REQ(MEAS_REQ),
   .CAL_REQ(CAL_REQ), .ALARM_O(ALARM_O), .ALARM_OE(ALARM_OE), .X_POS_COMP(X_POS_COMP),
   .X_NEG_COMP(X_NEG_COMP), .Y_POS_COMP(Y_POS_COMP), .Y_NEG_COMP(Y_NEG_COMP),
   .COMP_EN(COMP_EN), .TEMP_AVG_EXPONENT(TEMP_AVG_EXPONENT));
`default_nettype wire

// ### sense_data_monitor_control_tb_top.sv
// Self-checking bench for the sensor data monitor control block.
// Assumes the reader model and the bound checker are compiled before this file.
`timescale 1ns/1ps
`default_nettype none
module sense_data_monitor_control_tb_top;
   import sdmc_pkg::*;
   // A four-cycle minute keeps the start delay and period scenarios short.
   localparam int unsigned MINCYC = 4;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic ce = 1'b1;
   logic log_written = 1'b0;
   logic batt_dis = 1'b0;
   logic ext_pd = 1'b0;
   logic wr_stb, cmd_stb, meas_req, cal_req, power_down, alarm_o, alarm_oe;
   logic [7:0] wr_addr, rd_addr, cmd_code, cmd_byte, rsp_byte, log_addr, rsp;
   logic [31:0] wr_data, rd_data, d;
   logic [5:0] xp, xn, yp, yn;
   logic [3:0] comp_en, temp_exp;
   logic [2:0] ext_exp;
   sdmc_sample_s smp = '0;
   sdmc_result_s res;
   int error_cnt = 0;
   int tests_run = 0;
   always #20 clk = ~clk;
   sdmc_monitor #(.MINUTE_CYCLES(MINCYC)) i_dut (.CLK(clk), .RSTN(rstn), .CE(ce),
      .WR_STB(wr_stb), .WR_ADDR(wr_addr), .WR_DATA(wr_data), .RD_ADDR(rd_addr),
      .RD_DATA(rd_data), .CMD_STB(cmd_stb), .CMD_CODE(cmd_code), .CMD_BYTE(cmd_byte),
      .RSP_BYTE(rsp_byte), .SAMPLE(smp), .RESULT(res), .MEAS_REQ(meas_req),
      .CAL_REQ(cal_req), .LOG_ADDR(log_addr), .LOG_WRITTEN(log_written),
      .BATT_CHECK_DISABLE(batt_dis), .EXT_POWERDOWN_REQUEST(ext_pd),
      .POWER_DOWN(power_down), .ALARM_O(alarm_o), .ALARM_OE(alarm_oe), .X_POS_COMP(xp),
      .X_NEG_COMP(xn), .Y_POS_COMP(yp), .Y_NEG_COMP(yn), .COMP_EN(comp_en),
      .TEMP_AVG_EXPONENT(temp_exp), .EXT_AVG_EXPONENT(ext_exp));
   sdmc_reader i_rdr (.clk(clk), .wr_stb(wr_stb), .wr_addr(wr_addr), .wr_data(wr_data),
      .rd_addr(rd_addr), .rd_data(rd_data), .cmd_stb(cmd_stb), .cmd_code(cmd_code),
      .cmd_byte(cmd_byte), .rsp_byte(rsp_byte));
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic complete_run();
      if (error_cnt == 0 && tests_run > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic cmd(input logic [7:0] b, input logic [7:0] exp);
      i_rdr.cmd(8'ha0, b, rsp);
      chk("cmd_rsp", exp, rsp);
   endtask
   task automatic wait_meas(input logic v, input int n);
      while (meas_req !== v && n > 0) begin
         cyc(1);
         n--;
      end
      if (meas_req !== v) begin
         error_cnt++;
         $display("MISMATCH meas_req expected %b seen %b", v, meas_req);
         complete_run();
      end
   endtask
   task automatic pulse_log();
      @(posedge clk);
      #1 log_written = 1'b1;
      cyc(1);
      log_written = 1'b0;
   endtask
   task automatic send_sample(input logic [11:0] x, input logic [11:0] y, input logic low);
      @(posedge clk);
      #1 smp = '{x_avg: x, y_avg: y, temp_avg: 12'h3a5, valid: 1'b1, battery_low: low};
      cyc(1);
      smp = '{x_avg: ~x, y_avg: ~y, temp_avg: 12'hc5a, valid: 1'b0, battery_low: 1'b0};
      cyc(1);
   endtask
   task automatic t_reset();
      chk("rsp_rst", 8'h00, rsp_byte);
      chk("alarm_rst", 1'b0, alarm_oe);
      chk("log_addr_rst", 8'h1c, log_addr);
      i_rdr.rd(8'h10, d);
      chk("status_rst", 32'h0, d);
      i_rdr.rd(8'h14, d);
      chk("logcfg_rst", 32'h0000_00ff, d);
   endtask
   task automatic t_regs();
      for (int a = 8'h13; a <= 8'h1b; a++) begin
         if (a != 8'h14) begin
            i_rdr.wr(8'(a), 32'h0a53_0a00 + 32'(a));
            i_rdr.rd(8'(a), d);
            chk("reg_rw", 32'h0a53_0a00 + 32'(a), d);
         end
      end
      i_rdr.wr(8'h14, 32'h12ab_0f05);
      i_rdr.rd(8'h14, d);
      chk("log_end_clamp", 32'h12ab_0f1c, d);
      chk("temp_exp", 4'hf, temp_exp);
      i_rdr.rd(8'h40, d);
      chk("unmapped", 32'h0, d);
   endtask
   task automatic t_cmds();
      logic [23:0] tab [7] = '{24'ha0_04_04, 24'ha0_00_0e, 24'h21_08_0e, 24'ha0_08_08,
         24'ha0_00_00, 24'ha0_06_06, 24'ha0_08_0a};
      i_rdr.wr(8'h15, 32'h0);
      i_rdr.wr(8'h14, 32'h0000_00ff);
      foreach (tab[i]) begin
         i_rdr.cmd(tab[i][23:16], tab[i][15:8], rsp);
         chk("cmd_rsp", tab[i][7:0], rsp);
         if (i == 0) begin
            i_rdr.rd(8'h10, d);
            chk("status_start", 32'h0000_c000, d);
         end
      end
      chk("pdn_stop", 1'b1, power_down);
      i_rdr.cmd(8'ha0, 8'h20, rsp);
      chk("wake", 4'h1, rsp[7:4]);
      chk("pdn_wake", 1'b0, power_down);
   endtask
   task automatic t_alarm();
      i_rdr.wr(8'h14, 32'h0001_001e);
      // The wakeup state from the earlier 20h command stays set in bit 4.
      cmd(8'h04, 8'h14);
      pulse_log();
      cyc(2);
      chk("alarm_at_thr", 1'b0, alarm_oe);
      pulse_log();
      cyc(2);
      chk("alarm_above", 1'b1, alarm_oe);
      pulse_log();
      cyc(2);
      chk("full_stop", 1'b0, meas_req);
      chk("full_alarm", 1'b0, alarm_oe);
      i_rdr.rd(8'h10, d);
      chk("full_count", 8'h03, d[7:0]);
      cmd(8'h04, 8'h14);
      i_rdr.rd(8'h10, d);
      chk("count_clear", 8'h00, d[7:0]);
      i_rdr.wr(8'h15, 32'h0);
      i_rdr.rd(8'h10, d);
      chk("wr_clear", 32'h0, d);
   endtask
   task automatic t_norm();
      i_rdr.wr(8'h18, 32'h0002_0010);
      i_rdr.wr(8'h19, 32'h0fff_0000);
      send_sample(12'h100, 12'h010, 1'b0);
      chk("x_norm", 8'h21, res.x_norm);
      chk("y_norm", 8'hff, res.y_norm);
   endtask
   task automatic t_batt();
      cmd(8'h04, 8'h14);
      chk("meas_cont", 1'b1, meas_req);
      batt_dis = 1'b1;
      cyc(3);
      send_sample(12'h0, 12'h0, 1'b1);
      wait_meas(1'b1, 4);
      batt_dis = 1'b0;
      cyc(3);
      send_sample(12'h0, 12'h0, 1'b1);
      i_rdr.rd(8'h10, d);
      chk("batt_flag", 1'b1, d[11]);
      chk("batt_stop", 1'b0, meas_req);
      chk("batt_pdn", 1'b1, power_down);
   endtask
   task automatic t_cal();
      cmd(8'h05, 8'h15);
      chk("cal_req", 1'b1, cal_req);
      pulse_log();
      cyc(2);
      chk("cal_end", 2'b00, {cal_req, meas_req});
      chk("cal_pdn", 1'b1, power_down);
   endtask
   task automatic t_delay();
      i_rdr.wr(8'h15, 32'h0002_0001);
      cmd(8'h04, 8'h14);
      cyc(2);
      chk("delay_hold", 1'b0, meas_req);
      wait_meas(1'b1, 8);
      send_sample(12'h0, 12'h0, 1'b0);
      chk("period_hold", 1'b0, meas_req);
      wait_meas(1'b1, 8);
   endtask
   initial begin
      repeat (4) @(posedge clk);
      #1 rstn = 1'b1;
      cyc(1);
      t_reset();
      t_regs();
      t_cmds();
      t_alarm();
      t_norm();
      t_batt();
      t_cal();
      t_delay();
      complete_run();
   end
endmodule
`default_nettype wire
